/* logic/smc_defs.vh */
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// ----------------------------------------------------------------------
// Configuration word layout
// ----------------------------------------------------------------------
`define SMC_CFG_W       15
`define SMC_CFG_DIV_LO  0
`define SMC_CFG_DIV_HI  7
`define SMC_CFG_LSB     8
`define SMC_CFG_CPOL    9
`define SMC_CFG_CPHA    10
`define SMC_CFG_AUTO    11
`define SMC_CFG_INTEN   12
`define SMC_CFG_NSL_LO  13
`define SMC_CFG_NSL_HI  14

// Three slaves, divisor of 16, mode 0, MSB first, manual select.
`define SMC_CFG_RST     15'h6010

// ----------------------------------------------------------------------
// Transfer and timing constants
// ----------------------------------------------------------------------
`define SMC_LEN_MAX     6'h20
`define SMC_WORD_ZERO   32'h0000_0000
`define SMC_CLK_KHZ     200000
`define SMC_MAX_KBPS    16000
`define SMC_MIN_HALF    ((`SMC_CLK_KHZ + 2 * `SMC_MAX_KBPS - 1) / (2 * `SMC_MAX_KBPS))
`define SMC_FIFO_DEPTH  16
`define SMC_FIFO_AW     4

`endif

/* logic/smc_fifo.v */
module smc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    reg             full_reg;
    reg             empty_reg;

    wire push = in_valid & ~full_reg;
    wire pop  = out_ready & ~empty_reg;
    wire [AW:0] count_next = count_reg + {{AW{1'b0}}, push}
                                       - {{AW{1'b0}}, pop};

    assign in_ready  = ~full_reg;
    assign out_valid = ~empty_reg;
    assign out_data  = mem[rd_ptr_reg];

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Full and empty are kept as flags so the ready and valid seen by
    // both sides come straight from flip-flops.
    always @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            full_reg   <= 1'b0;
            empty_reg  <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            count_reg <= count_next;
            full_reg  <= (count_next == DEPTH[AW:0]);
            empty_reg <= (count_next == {(AW+1){1'b0}});
        end
    end

endmodule // smc_fifo

/* logic/smc_top.v */
// Summary of operation
// - At most first select plus one of second or third; never both.
// - Each transfer moves 1 to 32 bits, chosen at start.
// - Configuration picks LSB-first or MSB-first for both data lines.
// - Full duplex: word shifted out while equal-length word shifts in.
// - Bit clock divides system clock; rate capped at 16 Mbps.
// - With enable set, a pulse is raised at each completed transfer.
// - Polarity and phase select four clock modes.
// - Automatic selection asserts selects only during a transfer.
// - Manual selection asserts at once and holds across transfers.
// - Received word is right-justified in a 32-bit value.
// - Busy flag shows a transfer in progress.
// - Zero choice or stop command deasserts every select line.
// - Continuous mode waits until the received word is read.
// - Continuous mode starts the next transfer after that read.
// - Disabling continuous mode allows exactly one more transfer.
// - Configuration holds slaves, divisor, order, polarity, phase, etc.
// - Configuration is readable and can be written back unchanged.
`include "smc_defs.vh"

module smc_top (
    input  wire                    sys_clk,
    input  wire                    rst,
    input  wire                    cfg_wr,
    input  wire [`SMC_CFG_W-1:0]   cfg_wdata,
    output wire [`SMC_CFG_W-1:0]   cfg_rdata,
    input  wire                    sel_wr,
    input  wire [2:0]              sel_data,
    input  wire                    stop,
    input  wire                    start,
    input  wire                    cont_on,
    input  wire                    cont_off,
    input  wire [5:0]              xfer_len,
    input  wire [31:0]             tx_data,
    output wire                    busy,
    output wire                    cont_run,
    output wire                    xfer_irq,
    output wire [31:0]             rx_data,
    output wire                    rx_valid,
    input  wire                    rx_ready,
    output wire                    sclk,
    output wire                    mosi,
    input  wire                    miso,
    output wire                    slave_select_first_n,
    output wire                    slave_select_second_n,
    output wire                    slave_select_third_n
);

    // ------------------------------------------------------------------
    // States and constants
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_RUN   = 2'b01;
    localparam [1:0] ST_STORE = 2'b10;
    localparam integer MIN_HALF = `SMC_MIN_HALF;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function [5:0] fix_len;
        input [5:0] len;
        begin
            if (len == 6'h00 || len > `SMC_LEN_MAX) begin
                fix_len = `SMC_LEN_MAX;
            end else begin
                fix_len = len;
            end
        end
    endfunction

    function [31:0] align_tx;
        input [31:0] data;
        input [5:0]  len;
        input        lsb;
        begin
            if (lsb) begin
                align_tx = data;
            end else begin
                align_tx = data << (`SMC_LEN_MAX - len);
            end
        end
    endfunction

    function cur_bit;
        input [31:0] sh;
        input        lsb;
        begin
            cur_bit = lsb ? sh[0] : sh[31];
        end
    endfunction

    function [31:0] shift_tx;
        input [31:0] sh;
        input        lsb;
        begin
            shift_tx = lsb ? {1'b0, sh[31:1]} : {sh[30:0], 1'b0};
        end
    endfunction

    function [31:0] shift_rx;
        input [31:0] sh;
        input        bit_in;
        input        lsb;
        begin
            shift_rx = lsb ? {bit_in, sh[31:1]} : {sh[30:0], bit_in};
        end
    endfunction

    function [31:0] justify;
        input [31:0] sh;
        input [5:0]  len;
        input        lsb;
        begin
            if (lsb) begin
                justify = sh >> (`SMC_LEN_MAX - len);
            end else begin
                justify = sh;
            end
        end
    endfunction

    // Drops the third line when the second is also chosen, and any line
    // beyond the configured number of slaves.
    function [2:0] legal_sel;
        input [2:0] sel;
        input [1:0] nsl;
        reg   [2:0] s;
        begin
            s = sel;
            if (s[1] && s[2]) begin
                s[2] = 1'b0;
            end
            legal_sel = s & {(nsl > 2'd2), (nsl > 2'd1), (nsl > 2'd0)};
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [`SMC_CFG_W-1:0] cfg_reg;
    reg [1:0]            state_reg;
    reg [7:0]            half_reg;
    reg [6:0]            edge_reg;
    reg [5:0]            len_reg;
    reg [5:0]            cont_len_reg;
    reg [31:0]           tx_sh_reg;
    reg [31:0]           rx_sh_reg;
    reg                  sclk_reg;
    reg                  mosi_reg;
    reg                  busy_reg;
    reg                  irq_reg;
    reg                  cont_act_reg;
    reg                  cont_last_reg;
    reg [2:0]            sel_reg;
    reg [2:0]            ss_n_reg;
    reg                  miso_meta_reg;
    reg                  miso_sync_reg;

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    wire [7:0] cfg_div  = cfg_reg[`SMC_CFG_DIV_HI:`SMC_CFG_DIV_LO];
    wire       cfg_lsb  = cfg_reg[`SMC_CFG_LSB];
    wire       cfg_cpol = cfg_reg[`SMC_CFG_CPOL];
    wire       cfg_cpha = cfg_reg[`SMC_CFG_CPHA];
    wire       cfg_auto = cfg_reg[`SMC_CFG_AUTO];
    wire       cfg_inte = cfg_reg[`SMC_CFG_INTEN];
    wire [1:0] cfg_nsl  = cfg_reg[`SMC_CFG_NSL_HI:`SMC_CFG_NSL_LO];

    // Divisors below the rate limit are raised to it, so the bit rate
    // never exceeds the ceiling whatever software programs.
    wire [7:0] half_load = ((cfg_div < MIN_HALF[7:0]) ? MIN_HALF[7:0]
                            : cfg_div) - 8'h01;

    // ------------------------------------------------------------------
    // Start decision
    // ------------------------------------------------------------------
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire       idle     = (state_reg == ST_IDLE);
    wire       cont_go  = cont_act_reg & ~fifo_out_valid;
    wire       go       = idle & ~stop & (start | cont_on | cont_go);
    wire [5:0] go_len   = (start | cont_on) ? fix_len(xfer_len)
                                            : cont_len_reg;
    wire [31:0] go_word = align_tx(tx_data, go_len, cfg_lsb);

    wire [6:0] total_edges = {len_reg, 1'b0};
    wire [6:0] edge_inc    = edge_reg + 7'h01;
    wire       tick        = (state_reg == ST_RUN) && (half_reg == 8'h00);
    wire       lead        = ~edge_reg[0];
    wire       samp_edge   = lead ^ cfg_cpha;
    wire       last_edge   = (edge_inc == total_edges);
    wire       push        = (state_reg == ST_STORE) & fifo_in_ready;

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            miso_meta_reg <= 1'b0;
            miso_sync_reg <= 1'b0;
        end else begin
            miso_meta_reg <= miso;
            miso_sync_reg <= miso_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and selection
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            cfg_reg <= `SMC_CFG_RST;
        end else if (cfg_wr) begin
            cfg_reg <= cfg_wdata;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            sel_reg  <= 3'h0;
            ss_n_reg <= 3'h7;
        end else begin
            if (stop) begin
                sel_reg <= 3'h0;
            end else if (sel_wr) begin
                sel_reg <= legal_sel(sel_data, cfg_nsl);
            end
            if (cfg_auto) begin
                ss_n_reg <= ~(legal_sel(sel_reg, cfg_nsl)
                              & {3{~idle}});
            end else begin
                ss_n_reg <= ~legal_sel(sel_reg, cfg_nsl);
            end
        end
    end

    // ------------------------------------------------------------------
    // Continuous mode control
    // ------------------------------------------------------------------
    // A disable only arms the last transfer; the run ends as that
    // transfer is launched, so exactly one more word follows.
    always @(posedge sys_clk) begin
        if (rst) begin
            cont_act_reg  <= 1'b0;
            cont_last_reg <= 1'b0;
            cont_len_reg  <= `SMC_LEN_MAX;
        end else if (stop) begin
            cont_act_reg  <= 1'b0;
            cont_last_reg <= 1'b0;
        end else if (cont_on) begin
            cont_act_reg  <= 1'b1;
            cont_last_reg <= 1'b0;
            cont_len_reg  <= fix_len(xfer_len);
        end else if (go && cont_go && !start && cont_last_reg) begin
            cont_act_reg  <= 1'b0;
            cont_last_reg <= 1'b0;
        end else if (cont_off && cont_act_reg) begin
            cont_last_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            half_reg  <= 8'h00;
            edge_reg  <= 7'h00;
            len_reg   <= `SMC_LEN_MAX;
            tx_sh_reg <= `SMC_WORD_ZERO;
            rx_sh_reg <= `SMC_WORD_ZERO;
            sclk_reg  <= 1'b0;
            mosi_reg  <= 1'b0;
            busy_reg  <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    sclk_reg <= cfg_cpol;
                    if (go) begin
                        state_reg <= ST_RUN;
                        busy_reg  <= 1'b1;
                        half_reg  <= half_load;
                        edge_reg  <= 7'h00;
                        len_reg   <= go_len;
                        rx_sh_reg <= `SMC_WORD_ZERO;
                        // Phase 0 needs the first bit valid before the
                        // first edge; phase 1 drives it on that edge.
                        if (!cfg_cpha) begin
                            mosi_reg  <= cur_bit(go_word, cfg_lsb);
                            tx_sh_reg <= shift_tx(go_word, cfg_lsb);
                        end else begin
                            tx_sh_reg <= go_word;
                        end
                    end
                end
                ST_RUN: begin
                    if (!tick) begin
                        half_reg <= half_reg - 8'h01;
                    end else begin
                        half_reg <= half_load;
                        sclk_reg <= ~sclk_reg;
                        edge_reg <= edge_inc;
                        if (samp_edge) begin
                            rx_sh_reg <= shift_rx(rx_sh_reg, miso_sync_reg,
                                                  cfg_lsb);
                        end else if (!last_edge) begin
                            mosi_reg  <= cur_bit(tx_sh_reg, cfg_lsb);
                            tx_sh_reg <= shift_tx(tx_sh_reg, cfg_lsb);
                        end
                        if (last_edge) begin
                            state_reg <= ST_STORE;
                        end
                    end
                end
                ST_STORE: begin
                    // A full receive buffer stalls here with busy held.
                    if (fifo_in_ready) begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                        irq_reg   <= cfg_inte;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------------
    smc_fifo #(
        .WIDTH (32),
        .DEPTH (`SMC_FIFO_DEPTH),
        .AW    (`SMC_FIFO_AW)
    ) u_rx_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (justify(rx_sh_reg, len_reg, cfg_lsb)),
        .out_valid (fifo_out_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfg_rdata             = cfg_reg;
    assign busy                  = busy_reg;
    assign cont_run              = cont_act_reg;
    assign xfer_irq              = irq_reg;
    assign rx_valid              = fifo_out_valid;
    assign sclk                  = sclk_reg;
    assign mosi                  = mosi_reg;
    assign slave_select_first_n  = ss_n_reg[0];
    assign slave_select_second_n = ss_n_reg[1];
    assign slave_select_third_n  = ss_n_reg[2];

endmodule // smc_top

/* tb/smc_properties.sv */
`include "smc_defs.vh"

module smc_properties (
    input wire        sys_clk,
    input wire        rst,
    input wire        cfg_wr,
    input wire [14:0] cfg_wdata,
    input wire [14:0] cfg_rdata,
    input wire        sel_wr,
    input wire [2:0]  sel_data,
    input wire        stop,
    input wire        start,
    input wire        cont_on,
    input wire [5:0]  xfer_len,
    input wire        busy,
    input wire        xfer_irq,
    input wire        rx_valid,
    input wire        sclk,
    input wire        slave_select_first_n,
    input wire        slave_select_second_n,
    input wire        slave_select_third_n
);
    timeunit 1ns;
    timeprecision 100ps;

    wire       auto_w  = cfg_rdata[`SMC_CFG_AUTO];
    wire       inten_w = cfg_rdata[`SMC_CFG_INTEN];
    wire [1:0] nsl_w   = cfg_rdata[`SMC_CFG_NSL_HI:`SMC_CFG_NSL_LO];
    wire       idle_w  = slave_select_first_n && slave_select_second_n &&
                         slave_select_third_n;

    // ------------------------------------------------------------------
    // Serial clock edge count over one transfer
    // ------------------------------------------------------------------
    logic       sclk_q;
    logic       busy_q;
    logic [6:0] edges_reg;
    logic [5:0] len_reg;

    always @(posedge sys_clk) begin
        sclk_q <= sclk;
        busy_q <= busy;
        if ((start || cont_on) && !busy && !stop)
            len_reg <= (xfer_len == 6'h00 || xfer_len > 6'h20) ? 6'h20
                                                               : xfer_len;
        if (busy && !busy_q)
            edges_reg <= 7'h00;
        else if (sclk != sclk_q)
            edges_reg <= edges_reg + 7'h01;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_SEL_PAIR: assert property (slave_select_second_n || slave_select_third_n)
        else $error("Second and third selects low together.");
    AST_RST_SEL: assert property ($fell(rst) |-> idle_w && !busy && cfg_rdata == 15'h6010)
        else $error("State after reset is wrong.");
    AST_BUSY_START: assert property ((start || cont_on) && !busy && !stop |=> busy)
        else $error("Busy did not rise after a start.");
    AST_EDGES: assert property ($fell(busy) |-> edges_reg == {len_reg, 1'b0})
        else $error("Serial clock edge count differs from length.");
    AST_IRQ: assert property (xfer_irq == ($fell(busy) && inten_w))
        else $error("Completion pulse wrong.");
    AST_RX_STORED: assert property ($fell(busy) |-> rx_valid)
        else $error("Busy fell before the word was stored.");
    AST_AUTO_IDLE: assert property (auto_w && $past(auto_w) && $past(auto_w, 2) && !busy && !$past(busy) && !$past(busy, 2) |-> idle_w)
        else $error("Select low between automatic transfers.");
    AST_MAN_SEL: assert property (sel_wr && !stop && !auto_w && nsl_w != 2'h0 ##1 !sel_wr && !stop |=> slave_select_first_n == !$past(sel_data[0], 2))
        else $error("Manual first select did not follow.");
    AST_STOP_SEL: assert property (stop && !sel_wr && !auto_w ##1 !sel_wr |=> idle_w)
        else $error("Stop left a select low.");
    AST_CFG_RB: assert property (cfg_wr |=> cfg_rdata == $past(cfg_wdata))
        else $error("Configuration read back differs.");
endmodule // smc_properties

bind smc_top smc_properties u_props (
    .sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .sel_wr(sel_wr), .sel_data(sel_data),
    .stop(stop), .start(start), .cont_on(cont_on), .xfer_len(xfer_len),
    .busy(busy), .xfer_irq(xfer_irq), .rx_valid(rx_valid), .sclk(sclk),
    .slave_select_first_n(slave_select_first_n),
    .slave_select_second_n(slave_select_second_n),
    .slave_select_third_n(slave_select_third_n));

/* tb/smc_slave_model.sv */
module smc_slave_model (
    input  wire         sclk,
    input  wire         cs_n,
    input  wire         arm,
    input  wire         mosi,
    input  wire         cpol,
    input  wire         cpha,
    input  wire         lsb,
    input  wire  [5:0]  len,
    input  wire  [31:0] word,
    output logic        miso,
    output logic [31:0] got
);
    timeunit 1ns;
    timeprecision 100ps;
    int sent;
    int taken;

    function automatic logic pick(int k);
        return lsb ? word[k] : word[len - 1 - k];
    endfunction

    initial miso = 1'b0;

    // A held select spans several words, so arm starts a new one too.
    always @(posedge arm or negedge cs_n) begin
        taken = 0;
        got = 32'h0000_0000;
        miso = cpha ? ~miso : pick(0);
        sent = cpha ? 0 : 1;
    end

    // The line floats when deselected, so show a changed level.
    always @(posedge cs_n) miso = ~miso;

    always @(sclk) begin
        if (!cs_n && (sclk ^ cpol ^ cpha)) begin
            got = lsb ? got | (32'(mosi) << taken) : {got[30:0], mosi};
            taken++;
        end else if (!cs_n && sent < len) begin
            miso = pick(sent);
            sent++;
        end
    end
endmodule // smc_slave_model

/* tb/smc_top_bench.sv */
module smc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk, rst, cfg_wr, sel_wr, stop, start, cont_on, cont_off;
    logic        rx_ready, arm;
    logic [14:0] cfg_wdata;
    logic [2:0]  sel_data;
    logic [5:0]  xfer_len, mlen;
    logic [31:0] tx_data, sword, seed;
    logic [31:0] exp_q[$];
    wire  [14:0] cfg_rdata;
    wire         busy, cont_run, xfer_irq, rx_valid, sclk, mosi, miso;
    wire         ss0_n, ss1_n, ss2_n;
    wire  [31:0] rx_data, got;
    int          miscompares, comparisons, cycles, irqs;

    smc_top u_dut (
        .sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .sel_wr(sel_wr), .sel_data(sel_data),
        .stop(stop), .start(start), .cont_on(cont_on), .cont_off(cont_off),
        .xfer_len(xfer_len), .tx_data(tx_data), .busy(busy),
        .cont_run(cont_run), .xfer_irq(xfer_irq), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .sclk(sclk), .mosi(mosi),
        .miso(miso), .slave_select_first_n(ss0_n),
        .slave_select_second_n(ss1_n), .slave_select_third_n(ss2_n));

    smc_slave_model u_slave (
        .sclk(sclk), .cs_n(ss0_n), .arm(arm), .mosi(mosi),
        .cpol(cfg_wdata[9]), .cpha(cfg_wdata[10]), .lsb(cfg_wdata[8]),
        .len(mlen), .word(sword), .miso(miso), .got(got));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    always @(negedge sys_clk) if (xfer_irq === 1'b1) irqs++;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            conclude();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Lengths of zero or above the maximum move a whole word.
    function automatic logic [31:0] fit(logic [5:0] n, logic [31:0] w);
        return (n == 6'h00 || n > 6'h20) ? w : w & ((32'h0000_0001 << n) - 1);
    endfunction

    task automatic chk(logic [31:0] g, logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wait_busy(logic v);
        int n;
        n = 0;
        while (busy !== v && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(32'(busy), 32'(v));
    endtask

    task automatic setcfg(logic [14:0] c);
        @(negedge sys_clk);
        cfg_wr = 1'b1;
        cfg_wdata = c;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        chk(32'(cfg_rdata), 32'(c));
    endtask

    task automatic sel(logic [2:0] v, logic s);
        @(negedge sys_clk);
        sel_wr = !s;
        stop = s;
        sel_data = v;
        @(negedge sys_clk);
        {sel_wr, stop} = 2'h0;
        @(negedge sys_clk);
        chk({ss2_n, ss1_n, ss0_n},
            3'h7 ^ (s ? 3'h0 : v[1] ? v & 3'h3 : v));
    endtask

    task automatic pop(logic [31:0] e);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        chk(rx_data, e);
        rx_ready = 1'b1;
        @(negedge sys_clk);
        rx_ready = 1'b0;
    endtask

    task automatic launch(logic [5:0] n);
        tx_data = rnd();
        sword = rnd();
        xfer_len = n;
        mlen = (n == 6'h00 || n > 6'h20) ? 6'h20 : n;
        arm = 1'b1;
        @(negedge sys_clk);
        arm = 1'b0;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        chk(32'(busy), 32'h0000_0001);
        @(negedge sys_clk);
        chk(32'(ss0_n), 32'h0000_0000);
    endtask

    task automatic xfer(logic [5:0] n, logic ie);
        int i0;
        i0 = irqs;
        launch(n);
        wait_busy(1'b0);
        @(negedge sys_clk);
        chk(got, fit(n, tx_data));
        chk(irqs - i0, 32'(ie));
        pop(fit(n, sword));
    endtask

    task automatic conclude();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h0000_FC64;
        {rst, cfg_wr, sel_wr, stop, start, cont_on, cont_off} = 7'h40;
        {rx_ready, arm, sel_data} = 5'h00;
        {cfg_wdata, xfer_len, mlen} = {15'h6010, 6'h01, 6'h01};
        {tx_data, sword} = 64'h0;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        chk(32'(cfg_rdata), 32'h0000_6010);
        chk(32'({ss2_n, ss1_n, ss0_n, busy}), 32'h0000_000E);
        $display("reset test done");
        setcfg(15'h7010);
        sel(3'h7, 1'b0);
        xfer(6'h10, 1'b1);
        xfer(6'h10, 1'b1);
        chk(32'(ss0_n), 32'h0000_0000);
        sel(3'h0, 1'b0);
        sel(3'h5, 1'b0);
        sel(3'h5, 1'b1);
        sel(3'h1, 1'b0);
        $display("manual select test done");
        for (int m = 0; m < 8; m++) begin
            setcfg({2'h3, m[1] ^ m[0], 1'h1, m[2], m[1], m[0], 8'h10});
            xfer(m == 0 ? 6'h01 : m == 7 ? 6'h20 : m == 3 ? 6'h00
                 : 6'(rnd()) | 6'h01, cfg_wdata[12]);
        end
        $display("mode and order test done");
        setcfg(15'h7810);
        {tx_data, sword} = {rnd(), rnd()};
        {xfer_len, mlen} = {6'h08, 6'h08};
        cont_on = 1'b1;
        @(negedge sys_clk);
        cont_on = 1'b0;
        for (int k = 0; k < 3; k++) begin
            wait_busy(1'b0);
            repeat (20) @(negedge sys_clk);
            chk(32'(busy), 32'h0000_0000);
            chk(got, fit(6'h08, tx_data));
            cont_off = (k == 1);
            @(negedge sys_clk);
            cont_off = 1'b0;
            pop(fit(6'h08, sword));
            if (k < 2)
                wait_busy(1'b1);
        end
        repeat (40) @(negedge sys_clk);
        chk(32'({busy, cont_run, rx_valid}), 32'h0000_0000);
        $display("continuous test done");
        setcfg(15'h6810);
        for (int i = 0; i < 17; i++) begin
            launch(6'h01);
            exp_q.push_back(fit(6'h01, sword));
            if (i < 16)
                wait_busy(1'b0);
        end
        repeat (100) @(negedge sys_clk);
        chk(32'(busy), 32'h0000_0001);
        while (exp_q.size() > 0)
            pop(exp_q.pop_front());
        chk(32'(rx_valid), 32'h0000_0000);
        $display("buffer fill test done");
        conclude();
    end
endmodule // smc_top_bench
